// [design/prach_ctrl_regs.svh]
// register offsets, field positions, reset values and timing counts for the random access controller
`ifndef PRACH_CTRL_REGS_SVH
`define PRACH_CTRL_REGS_SVH

`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_IRQ_STATUS  12'h008
`define OFS_IRQ_MASK    12'h00c
`define OFS_CYCLE_CFG   12'h010
`define OFS_RAMP_CFG    12'h014
`define OFS_POWER_CFG   12'h018
`define OFS_ASC_CFG     12'h01c
`define OFS_POWER_OUT   12'h020
`define OFS_SEED        12'h024

`define CTRL_START_BIT  0
`define CTRL_ABORT_BIT  1
`define CTRL_ENABLE_BIT 2
`define CTRL_TIMING_BIT 3

`define IRQ_W             6
`define IRQ_MSG_SENT      0
`define IRQ_NACK          1
`define IRQ_NO_ACK        2
`define IRQ_CYCLE_FAIL    3
`define IRQ_ABORTED       4
`define IRQ_PREAMBLE      5

`define NACK_MARGIN_DB    9'sh006
`define OFFSET_AI_SHORT   3'h3
`define OFFSET_AI_LONG    3'h4
`define SEED_RESET        16'hace1
`define LFSR_TAPS         16'hb400
`define SLOTS_PER_SET     4'hf

`endif

// [design/prach_ctrl_pkg.sv]
// types shared by the random access controller
package prach_ctrl_pkg;

	typedef enum logic [3:0] {
		st_idle      = 4'b0000,
		st_cycle     = 4'b0001,
		st_persist   = 4'b0010,
		st_pick_slot = 4'b0011,
		st_power     = 4'b0100,
		st_wait_slot = 4'b0101,
		st_wait_ai   = 4'b0110,
		st_wait_msg  = 4'b0111,
		st_done      = 4'b1000
	} ra_state_t;

	// downlink indicator decision for one access slot
	typedef struct packed {
		logic       valid;
		logic       positive;
		logic       negative;
		logic [3:0] signature;
	} ai_decision_t;

	// preamble or message burst request toward the radio
	typedef struct packed {
		logic             preamble;
		logic             message;
		logic [3:0]       slot;
		logic [3:0]       signature;
		logic signed [7:0] power_db;
	} tx_req_t;

endpackage

// [design/prach_ctrl.sv]
// random access preamble ramp controller with apb register slave
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "prach_ctrl_regs.svh"

module prach_ctrl
	import prach_ctrl_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic              pready,
	output logic [31:0]       prdata,
	output logic              pslverr,
	input  wire logic         frame_tick,
	input  wire logic         slot_tick,
	input  wire logic [3:0]   slot_index,
	input  wire logic         data_pending,
	input  wire logic         response_received,
	input  wire ai_decision_t ai_in,
	output tx_req_t           tx_out,
	output logic              irq
);

	// software-visible configuration; the broadcast copy is what cycles reload from
	logic [7:0]        ctrl;
	logic [15:0]       cycle_cfg;     // [7:0] max cycles, [15:8] persistence threshold
	logic [15:0]       ramp_cfg;      // [7:0] max periods, [15:8] max preamble retrans
	logic [31:0]       power_cfg;     // init, max, step, message offset (signed db)
	logic [31:0]       asc_cfg;       // [7:0] class sub-channels, [23:8] signatures per class
	logic [15:0]       seed;
	logic [`IRQ_W-1:0] irq_status;
	logic [`IRQ_W-1:0] irq_mask;

	// working copies reloaded each retransmission cycle
	logic [7:0]        max_cycles;
	logic [7:0]        persist_thr;
	logic [7:0]        max_periods;
	logic [7:0]        max_retrans;
	logic signed [7:0] init_power;
	logic signed [7:0] max_power;
	logic signed [7:0] ramp_step;
	logic signed [7:0] msg_offset;
	logic [15:0]       subch_mask;
	logic [15:0]       sig_mask;
	logic              timing_long;

	ra_state_t         state;
	logic [7:0]        cycle_cnt;
	logic [7:0]        period_cnt;
	logic [7:0]        retrans_cnt;
	logic signed [8:0] cmd_power;
	logic [3:0]        sel_slot;
	logic [3:0]        sel_sig;
	logic [2:0]        msg_wait;
	logic [15:0]       lfsr;
	logic [1:0]        ev_done;       // 0 sent, 1 nack, 2 no ack, 3 cycle fail
	logic [`IRQ_W-1:0] events;

	logic              wr_en;
	logic              rd_en;
	logic              start_req;
	logic              abort_req;
	logic [3:0]        rnd_slot;
	logic [3:0]        rnd_sig;
	logic              slot_ok;
	logic              sig_ok;
	logic signed [8:0] tx_power;
	logic signed [8:0] over_limit;
	logic signed [8:0] max_power_ext;
	logic signed [8:0] step_ext;

	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign start_req = wr_en && paddr == `OFS_CTRL && pwdata[`CTRL_START_BIT];
	assign abort_req = wr_en && paddr == `OFS_CTRL && pwdata[`CTRL_ABORT_BIT];
	assign irq = |(irq_status & irq_mask);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lfsr <= `SEED_RESET;
		end else if (wr_en && paddr == `OFS_SEED) begin
			lfsr <= (pwdata[15:0] == 16'h0000) ? `SEED_RESET : pwdata[15:0];
		end else begin
			lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `LFSR_TAPS : 16'h0000);
		end
	end

	// random candidates; the signature is accepted only when permitted for the class, the slot check uses the live slot index
	assign rnd_slot = lfsr[3:0];
	assign rnd_sig  = lfsr[11:8];
	assign slot_ok  = subch_mask[slot_index[3:0]];
	assign sig_ok   = sig_mask[rnd_sig];

	// sign-extended copies keep every power compare signed
	assign max_power_ext = {max_power[7], max_power};
	assign step_ext      = {ramp_step[7], ramp_step};

	assign tx_power   = (cmd_power > max_power_ext) ? max_power_ext : cmd_power;
	assign over_limit = cmd_power - max_power_ext;

	// register writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl      <= 8'h00;
			cycle_cfg <= 16'h0004;
			ramp_cfg  <= 16'h0404;
			power_cfg <= 32'h02_02_18_f6;
			asc_cfg   <= 32'h00ffff_ff;
			irq_mask  <= '0;
			seed      <= `SEED_RESET;
		end else if (wr_en) begin
			if (paddr == `OFS_CTRL) begin
				ctrl <= pwdata[7:0] & 8'hfc;   // start and abort are self-clearing
			end else if (paddr == `OFS_IRQ_MASK) begin
				irq_mask <= pwdata[`IRQ_W-1:0];
			end else if (paddr == `OFS_CYCLE_CFG) begin
				cycle_cfg <= pwdata[15:0];
			end else if (paddr == `OFS_RAMP_CFG) begin
				ramp_cfg <= pwdata[15:0];
			end else if (paddr == `OFS_POWER_CFG) begin
				power_cfg <= pwdata;
			end else if (paddr == `OFS_ASC_CFG) begin
				asc_cfg <= pwdata;
			end else if (paddr == `OFS_SEED) begin
				seed <= pwdata[15:0];
			end
		end
	end

	// sticky events, set wins over write-one-to-clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= ((wr_en && paddr == `OFS_IRQ_STATUS) ? irq_status & ~pwdata[`IRQ_W-1:0] : irq_status)
				| events;
		end
	end

	// main procedure; only the persistence, slot and message waits advance on frame or slot ticks
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state       <= st_idle;
			cycle_cnt   <= 8'h00;
			period_cnt  <= 8'h00;
			retrans_cnt <= 8'h00;
			cmd_power   <= '0;
			sel_slot    <= 4'h0;
			sel_sig     <= 4'h0;
			msg_wait    <= 3'h0;
			max_cycles  <= 8'h00;
			persist_thr <= 8'h00;
			max_periods <= 8'h00;
			max_retrans <= 8'h00;
			init_power  <= '0;
			max_power   <= '0;
			ramp_step   <= '0;
			msg_offset  <= '0;
			subch_mask  <= 16'h0000;
			sig_mask    <= 16'h0000;
			timing_long <= 1'b0;
			events      <= '0;
			tx_out      <= '0;
		end else begin
			events <= '0;
			tx_out.preamble <= 1'b0;
			tx_out.message  <= 1'b0;
			if ((response_received || abort_req) && state != st_idle) begin
				state <= st_idle;
				events[`IRQ_ABORTED] <= 1'b1;
			end else begin
				case (state)
					st_idle: begin
						if ((data_pending && ctrl[`CTRL_ENABLE_BIT]) || start_req) begin
							cycle_cnt <= 8'h00;
							state     <= st_cycle;
						end
					end
					st_cycle: begin
						if (cycle_cnt >= max_cycles && cycle_cnt != 8'h00) begin
							events[`IRQ_CYCLE_FAIL] <= 1'b1;
							state <= st_idle;
						end else begin
							max_cycles  <= cycle_cfg[7:0];
							persist_thr <= cycle_cfg[15:8];
							max_periods <= ramp_cfg[7:0];
							max_retrans <= ramp_cfg[15:8];
							init_power  <= power_cfg[7:0];
							max_power   <= power_cfg[15:8];
							ramp_step   <= power_cfg[23:16];
							msg_offset  <= power_cfg[31:24];
							subch_mask  <= {asc_cfg[7:0], asc_cfg[7:0]};
							sig_mask    <= asc_cfg[23:8];
							timing_long <= ctrl[`CTRL_TIMING_BIT];
							cycle_cnt   <= cycle_cnt + 8'h01;
							period_cnt  <= 8'h00;
							state       <= st_persist;
						end
					end
					st_persist: begin
						if (frame_tick) begin
							if (period_cnt >= max_periods) begin
								state <= st_cycle;
							end else if (lfsr[15:8] < persist_thr) begin
								period_cnt <= period_cnt + 8'h01;
								retrans_cnt <= max_retrans;
								cmd_power <= {init_power[7], init_power};
								state <= st_pick_slot;
							end
						end
					end
					// random slot and signature
					// slot index 15 does not exist in a set, so a first pick of it is redrawn;
					// retries keep the next-slot choice made after the miss
					st_pick_slot: begin
						if (sig_ok && (retrans_cnt != max_retrans || rnd_slot < `SLOTS_PER_SET)) begin
							sel_sig <= rnd_sig;
							if (retrans_cnt == max_retrans) begin
								sel_slot <= rnd_slot;
							end
							state <= st_wait_slot;
						end
					end
					// wait for usable slot, skipping to later sets
					st_wait_slot: begin
						if (slot_tick && slot_ok && (slot_index == sel_slot || !subch_mask[sel_slot])) begin
							sel_slot <= slot_index;
							state    <= st_power;
						end
					end
					st_power: begin
						tx_out.preamble  <= 1'b1;
						tx_out.slot      <= sel_slot;
						tx_out.signature <= sel_sig;
						tx_out.power_db  <= tx_power[7:0];
						events[`IRQ_PREAMBLE] <= 1'b1;
						state <= st_wait_ai;
					end
					st_wait_ai: begin
						if (ai_in.valid && ai_in.signature == sel_sig && ai_in.positive) begin
							// message after three or four slots
							msg_wait <= timing_long ? `OFFSET_AI_LONG : `OFFSET_AI_SHORT;
							state    <= st_wait_msg;
						end else if (ai_in.valid && ai_in.signature == sel_sig && ai_in.negative) begin
							events[`IRQ_NACK] <= 1'b1;
							state <= st_idle;
						end else if (ai_in.valid) begin
							cmd_power <= cmd_power + step_ext;
							retrans_cnt <= retrans_cnt - 8'h01;
							if (over_limit + step_ext > `NACK_MARGIN_DB
									|| retrans_cnt <= 8'h01) begin
								events[`IRQ_NO_ACK] <= 1'b1;
								state <= st_idle;
							end else begin
								sel_slot <= (slot_index == `SLOTS_PER_SET - 4'h1) ? 4'h0 : slot_index + 4'h1;
								state    <= st_pick_slot;
							end
						end
					end
					st_wait_msg: begin
						if (slot_tick) begin
							msg_wait <= msg_wait - 3'h1;
							if (msg_wait == 3'h1) begin
								tx_out.message  <= 1'b1;
								tx_out.slot     <= slot_index;
								tx_out.power_db <= tx_power[7:0] + msg_offset;
								state <= st_done;
							end
						end
					end
					st_done: begin
						events[`IRQ_MSG_SENT] <= 1'b1;
						state <= st_idle;
					end
					default: begin
						state <= st_idle;
					end
				endcase
			end
		end
	end

	// register reads, unmapped addresses read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == `OFS_CTRL) begin
				prdata <= {24'h000000, ctrl};
			end else if (paddr == `OFS_STATUS) begin
				prdata <= {4'h0, state, retrans_cnt, period_cnt, cycle_cnt};
			end else if (paddr == `OFS_IRQ_STATUS) begin
				prdata <= {{(32-`IRQ_W){1'b0}}, irq_status};
			end else if (paddr == `OFS_IRQ_MASK) begin
				prdata <= {{(32-`IRQ_W){1'b0}}, irq_mask};
			end else if (paddr == `OFS_CYCLE_CFG) begin
				prdata <= {16'h0000, cycle_cfg};
			end else if (paddr == `OFS_RAMP_CFG) begin
				prdata <= {16'h0000, ramp_cfg};
			end else if (paddr == `OFS_POWER_CFG) begin
				prdata <= power_cfg;
			end else if (paddr == `OFS_ASC_CFG) begin
				prdata <= asc_cfg;
			end else if (paddr == `OFS_POWER_OUT) begin
				prdata <= {23'h000000, cmd_power};
			end else if (paddr == `OFS_SEED) begin
				prdata <= {16'h0000, seed};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

endmodule // prach_ctrl
`default_nettype wire

// [verification/prach_ctrl_assertions.sv]
// port checks for the random access controller
`timescale 1ns/10ps
`default_nettype none
`include "prach_ctrl_regs.svh"
module prach_ctrl_assertions
	import prach_ctrl_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         rst,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pwrite,
	input wire logic [11:0]  paddr,
	input wire logic [31:0]  pwdata,
	input wire logic         pready,
	input wire logic         slot_tick,
	input wire logic         response_received,
	input wire ai_decision_t ai_in,
	input wire tx_req_t      tx_out,
	input wire logic         irq
);
	logic              wr;
	logic [31:0]       pcfg;
	logic [15:0]       smask;
	logic              lng;
	logic signed [7:0] last;
	logic [2:0]        tk;
	logic              nak;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	assign wr = psel && penable && pwrite && pready;
	// shadow of the settings written over apb
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pcfg <= '0;
			smask <= '0;
			lng <= 1'b0;
		end else if (wr) begin
			if (paddr == `OFS_POWER_CFG) pcfg <= pwdata;
			if (paddr == `OFS_ASC_CFG) smask <= pwdata[23:8];
			if (paddr == `OFS_CTRL) lng <= pwdata[`CTRL_TIMING_BIT];
		end
	end
	// last preamble level, slots since it, negative answer seen
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			last <= '0;
			tk <= '0;
			nak <= 1'b0;
		end else if (tx_out.preamble) begin
			last <= tx_out.power_db;
			tk <= '0;
			nak <= 1'b0;
		end else begin
			if (slot_tick && tk != 3'h7) tk <= tk + 3'h1;
			if (ai_in.valid && ai_in.negative) nak <= 1'b1;
		end
	end
	property p_pulse; tx_out.preamble |=> !tx_out.preamble && !tx_out.message; endproperty
	a_pulse: assert property (p_pulse) else $error("preamble not a lone pulse");
	property p_clip; tx_out.preamble |-> $signed(tx_out.power_db) <= $signed(pcfg[15:8]); endproperty
	a_clip: assert property (p_clip) else $error("preamble above maximum");
	property p_sig; tx_out.preamble |-> smask[tx_out.signature]; endproperty
	a_sig: assert property (p_sig) else $error("signature not permitted");
	property p_msgpw; tx_out.message |-> tx_out.power_db == last + pcfg[31:24]; endproperty
	a_msgpw: assert property (p_msgpw) else $error("message level wrong");
	property p_slot; tx_out.message |-> tk == (lng ? 3'h4 : 3'h3); endproperty
	a_slot: assert property (p_slot) else $error("message slot offset wrong");
	property p_nak; tx_out.message |-> !nak; endproperty
	a_nak: assert property (p_nak) else $error("message after negative answer");
	property p_end; tx_out.message |=> (!tx_out.message && !tx_out.preamble) [*8]; endproperty
	a_end: assert property (p_end) else $error("burst after message");
	property p_abort; response_received |-> ##2 (!tx_out.preamble && !tx_out.message) [*4]; endproperty
	a_abort: assert property (p_abort) else $error("burst after abort");
	property p_mask; wr && paddr == `OFS_IRQ_MASK && pwdata[5:0] == 6'h00 |-> ##2 !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq high while all masked");
endmodule // prach_ctrl_assertions
`default_nettype wire

// [verification/prach_far_side.sv]
// far side model: slot timing and acquisition indicator answers
`timescale 1ns/10ps
`default_nettype none
module prach_far_side
	import prach_ctrl_pkg::*;
#(
	parameter int SLOT_CYC = 24
)(
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire tx_req_t    tx_out,
	input  wire logic [1:0] ai_mode,
	input  wire logic [3:0] ai_delay,
	output logic            frame_tick,
	output logic            slot_tick,
	output logic [3:0]      slot_index,
	output ai_decision_t    ai_in
);
	int         cyc;
	int         due;
	logic [3:0] sig;
	// slot boundaries, fifteen slots to a frame
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cyc <= 0;
			slot_index <= 4'h0;
			slot_tick <= 1'b0;
			frame_tick <= 1'b0;
		end else begin
			cyc <= (cyc == SLOT_CYC - 1) ? 0 : cyc + 1;
			slot_tick <= (cyc == SLOT_CYC - 1);
			frame_tick <= (cyc == SLOT_CYC - 1) && (slot_index == 4'he);
			if (cyc == SLOT_CYC - 1) slot_index <= (slot_index == 4'he) ? 4'h0 : slot_index + 4'h1;
		end
	end
	// answer within slot
	// idle fields toggle so a stale answer is never trusted
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			due <= 0;
			sig <= 4'h0;
			ai_in <= '0;
		end else begin
			ai_in <= {1'b0, ~ai_in[5:0]};
			if (tx_out.preamble) begin
				due <= int'(ai_delay);
				sig <= tx_out.signature;
			end else if (due > 0) begin
				due <= due - 1;
				// mode 0 still reports a decision, with neither indicator set
				if (due == 1) ai_in <= {1'b1, ai_mode == 2'd1, ai_mode == 2'd2, sig};
			end
		end
	end
endmodule // prach_far_side
`default_nettype wire

// [verification/test_random_access_preamble_ramp_ctrl.sv]
// self-checking bench for the random access controller
`timescale 1ns/10ps
`default_nettype none
`include "prach_ctrl_regs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module test_random_access_preamble_ramp_ctrl
	import prach_ctrl_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = '0;
	logic [31:0]       pwdata = '0;
	logic              data_pending = 1'b0;
	logic              response_received = 1'b0;
	logic [1:0]        ai_mode = 2'd0;
	logic [3:0]        ai_delay = 4'h1;
	logic              pready, pslverr, frame_tick, slot_tick, irq;
	logic [31:0]       prdata;
	logic [3:0]        slot_index;
	ai_decision_t      ai_in;
	tx_req_t           tx_out;
	int                num_errors = 0;
	int                total_checks = 0;
	int                retr;
	logic signed [7:0] pq[$];
	logic signed [7:0] mq[$];
	always #2 ref_clk = ~ref_clk;
	prach_ctrl i_prach_ctrl (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.frame_tick(frame_tick), .slot_tick(slot_tick), .slot_index(slot_index), .data_pending(data_pending),
		.response_received(response_received), .ai_in(ai_in), .tx_out(tx_out), .irq(irq));
	prach_far_side i_prach_far_side (.ref_clk(ref_clk), .rst(rst), .tx_out(tx_out), .ai_mode(ai_mode),
		.ai_delay(ai_delay), .frame_tick(frame_tick), .slot_tick(slot_tick), .slot_index(slot_index), .ai_in(ai_in));
	// gather every burst the design sends
	always @(posedge ref_clk) begin
		if (tx_out.preamble === 1'b1) pq.push_back(tx_out.power_db);
		if (tx_out.message === 1'b1) mq.push_back(tx_out.power_db);
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// one apb transfer, held until pready is sampled high or 50 cycles pass
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask
	// bounded wait: first preamble (0) or irq (1)
	task automatic wait_for(input int what);
		int n;
		n = 0;
		while (n < 15000 && ((what == 0 && pq.size() == 0) || (what == 1 && irq !== 1'b1))) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(n < 15000, 1'b1)
	endtask
	// one procedure with random power settings, checked against the model
	task automatic run(input int mode, input logic tim, input logic pend, input logic abt, input int ebit);
		int init, step, maxp, ofs, cmd, n;
		logic [31:0] rv;
		logic signed [7:0] ex[$];
		init = -2 * int'($urandom_range(5, 0));
		step = 2 * int'($urandom_range(2, 1));
		maxp = 2 * int'($urandom_range(2, 0)) + 1;
		ofs = int'($urandom_range(5, 1));
		ai_mode <= 2'(mode);
		ai_delay <= 4'($urandom_range(12, 1));
		pq.delete();
		mq.delete();
		wr(`OFS_POWER_CFG, {8'(ofs), 8'(step), 8'(maxp), 8'(init)});
		cmd = init;
		n = retr;
		do begin
			ex.push_back(8'(cmd > maxp ? maxp : cmd));
			cmd += step;
			n--;
		end while (n > 0 && cmd <= maxp + 6 && mode == 0 && !abt);
		if (pend) data_pending <= 1'b1;
		wr(`OFS_CTRL, 32'(tim) << `CTRL_TIMING_BIT | 32'(!pend) << `CTRL_START_BIT | 32'(pend) << `CTRL_ENABLE_BIT);
		if (pend || abt) wait_for(0);
		data_pending <= 1'b0;
		response_received <= abt;
		@(posedge ref_clk);
		response_received <= 1'b0;
		wait_for(1);
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0, rv);
		`CHK(rv[4:0], 5'(1 << ebit))
		`CHK(pq.size(), ex.size())
		foreach (ex[i]) `CHK(pq[i], ex[i])
		`CHK(mq.size(), (mode == 1) ? 1 : 0)
		if (mode == 1) `CHK(mq[0], 8'(ex[0] + ofs))
		wr(`OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		wr(`OFS_IRQ_MASK, 32'h1f);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		wr(`OFS_IRQ_STATUS, 32'h3f);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0, rv);
		`CHK(rv[4:0], 5'h0)
	endtask
	initial begin
		logic [31:0] rv;
		void'($urandom(32'h4546));
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, `OFS_STATUS, 32'h0, rv);
		`CHK(rv, 32'h0)
		wr(12'h0fc, 32'hffff_ffff);
		apb(1'b0, 12'h0fc, 32'h0, rv);
		`CHK(rv, 32'h0)
		retr = int'($urandom_range(5, 2));
		wr(`OFS_SEED, 32'($urandom_range(16'hffff, 1)));
		wr(`OFS_CYCLE_CFG, 32'h0000_ff00);
		wr(`OFS_RAMP_CFG, {16'h0, 8'(retr), 8'h04});
		wr(`OFS_ASC_CFG, {8'h0, 16'($urandom) | 16'h0001, 8'hff});
		wr(`OFS_IRQ_MASK, 32'h1f);
		// no answer, positive both timings, negative, abort
		run(0, 1'b0, 1'b0, 1'b0, `IRQ_NO_ACK);
		run(1, 1'b0, 1'b0, 1'b0, `IRQ_MSG_SENT);
		run(1, 1'b1, 1'b1, 1'b0, `IRQ_MSG_SENT);
		run(2, 1'b1, 1'b0, 1'b0, `IRQ_NACK);
		run(0, 1'b0, 1'b0, 1'b1, `IRQ_ABORTED);
		summarize();
	end
	// watchdog against a hung procedure
	initial begin
		repeat (90000) @(posedge ref_clk);
		num_errors++;
		$display("[FAIL] %0t run did not finish", $time);
		summarize();
	end
endmodule // test_random_access_preamble_ramp_ctrl
bind prach_ctrl prach_ctrl_assertions i_prach_ctrl_assertions (.ref_clk(ref_clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .slot_tick(slot_tick),
	.response_received(response_received), .ai_in(ai_in), .tx_out(tx_out), .irq(irq));
`default_nettype wire
